//--- pfm_pkg.sv
package pfm_pkg;
   // block geometry
   localparam int CHANNELS = 3;
   localparam int MS_W = 14;

   // clock and time base
   localparam int CLK_PERIOD_NS = 5;
   localparam int NS_PER_MS = 1000000;
   localparam int CYCLES_PER_MS_DEF = NS_PER_MS / CLK_PERIOD_NS;

   // integration time limits and default, in ms
   localparam logic [31:0] INTEG_MIN_MS = 32'h0000000a;
   localparam logic [31:0] INTEG_MAX_MS = 32'h00002710;
   localparam logic [MS_W-1:0] INTEG_RESET_MS = 14'h0064;

   // count to millihertz: pulses * 1000 ms/s * 1000 mHz/Hz / ms
   localparam logic [63:0] MHZ_SCALE = 64'h00000000000f4240;
   localparam logic [30:0] FREQ_SAT = 31'h7fffffff;
   localparam logic [6:0] DIV_STEPS = 7'h40;

   // job codes
   localparam logic [15:0] JOB_NOP = 16'h0000;
   localparam logic [15:0] JOB_WR_INTEG = 16'h0004;
   localparam logic [15:0] JOB_RD_INTEG = 16'h0084;

   // job status codes
   localparam logic [15:0] STAT_OK = 16'h0000;
   localparam logic [15:0] STAT_TOO_LOW = 16'h0221;
   localparam logic [15:0] STAT_TOO_HIGH = 16'h0222;
   localparam logic [15:0] STAT_BAD_JOB = 16'h02ff;
   localparam logic [15:0] STAT_BAD_CHAN = 16'h8009;

   // interrupt selection
   typedef enum logic [1:0] {
      PFM_IRQ_NONE,
      PFM_IRQ_PROC,
      PFM_IRQ_DIAG_PROC
   } pfm_irqsel_t;

   // apb register offsets and fields
   localparam logic [11:0] REG_CTRL = 12'h000;
   localparam logic [11:0] REG_STATUS = 12'h004;
   localparam logic [11:0] REG_FREQ0 = 12'h008;
   localparam logic [11:0] REG_FREQ1 = 12'h00c;
   localparam logic [11:0] REG_FREQ2 = 12'h010;
   localparam int CTRL_EOM_BIT = 2;
   localparam int STS_PROC_BIT = 3;
   localparam int STS_LOST_BIT = 4;
   localparam logic [2:0] CTRL_RESET = 3'h0;
endpackage

//--- pfm_freq_meter.sv
// Summary of operation
// - count pulses per period, convert to frequency
// - integration time 10 to 10000 ms, 1 ms
// - result changes only at period end
// - no edge in period reports zero
// - result in millihertz, signed 32 bits
// - channels measure fully independently
// - measured signal taken from B input
// - interrupt select: none, process, diag plus process
// - end of period raises process interrupt
// - diagnostic interrupt only for lost interrupt
// - soft gate starts/stops; gate flag reported
// - job starts on rising job request
// - no new job before done; done idle
// - logical base address ignored
// - other configuration settings ignored
// - job codes: none, write, read time
// - job error flag with status code
// - read job value on read output
module pfm_freq_meter
   import pfm_pkg::*;
#(
   parameter int CYCLES_PER_MS = CYCLES_PER_MS_DEF
) (
   // clock, reset, enable
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic clkEn,
   // measurement inputs, B side of each channel
   input wire logic [CHANNELS-1:0] measInB,
   // soft gates and gate state
   input wire logic [CHANNELS-1:0] softGateEnable,
   output logic [CHANNELS-1:0] gateStateFlag,
   // evaluated frequencies in mHz
   output logic [31:0] measuredFrequency0,
   output logic [31:0] measuredFrequency1,
   output logic [31:0] measuredFrequency2,
   // job request interface
   input wire logic jobReq,
   input wire logic [1:0] jobChannel,
   input wire logic [15:0] jobCode,
   input wire logic [31:0] jobWriteValue,
   input wire logic [15:0] logicalBaseAddress,
   output logic jobDone,
   output logic jobErr,
   output logic [15:0] jobStat,
   output logic [31:0] jobReadValue,
   // interrupts
   output logic procIrq,
   output logic diagIrq,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);

   logic [MS_W-1:0] integMs [CHANNELS];
   logic [31:0] freq [CHANNELS];
   logic [CHANNELS-1:0] endEv;
   logic [CHANNELS-1:0] prevB;
   logic jobReqPrev;
   logic jobPend;
   logic [1:0] irqSel;
   logic eomEnable;
   logic lostFlag;
   logic apbAccess;
   logic apbWrite;
   logic clrProc;
   logic clrLost;

   assign measuredFrequency0 = freq[0];
   assign measuredFrequency1 = freq[1];
   assign measuredFrequency2 = freq[2];
   assign apbAccess = psel & penable & ~pready;
   // writes land on the edge where the master sees pready, not before
   assign apbWrite = psel & penable & pready & pwrite;
   assign clrProc = apbWrite & (paddr == REG_STATUS) & pwdata[STS_PROC_BIT];
   assign clrLost = apbWrite & (paddr == REG_STATUS) & pwdata[STS_LOST_BIT];

   // input history for edge detection, one shared register per concern
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         prevB <= '0;
      end else if (clkEn) begin
         prevB <= measInB;
      end
   end

   // each channel owns its counters and divider, nothing shared
   for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
      logic [31:0] cycCnt;
      logic [MS_W-1:0] msCnt;
      logic [MS_W-1:0] curMs;
      logic [31:0] pulses;
      logic risingB;
      logic msTick;
      logic periodEnd;
      logic [63:0] quo;
      logic [MS_W-1:0] rem;
      logic [MS_W-1:0] divisor;
      logic [6:0] steps;
      logic divBusy;
      logic [MS_W:0] trial;

      assign risingB = measInB[ch] & ~prevB[ch];
      assign msTick = (cycCnt == 32'(CYCLES_PER_MS - 1));
      // a gate closing in the last cycle must not report the cut period
      assign periodEnd = gateStateFlag[ch] & softGateEnable[ch] & msTick
         & (msCnt == curMs - 14'h0001);
      assign trial = {rem, quo[63]};

      // gate follow, pulse counting and period timing
      always_ff @(posedge sys_clk or negedge resetn) begin
         if (!resetn) begin
            gateStateFlag[ch] <= 1'b0;
            cycCnt <= '0;
            msCnt <= '0;
            curMs <= INTEG_RESET_MS;
            pulses <= '0;
            endEv[ch] <= 1'b0;
         end else if (clkEn) begin
            gateStateFlag[ch] <= softGateEnable[ch];
            endEv[ch] <= periodEnd;
            if (softGateEnable[ch] && !gateStateFlag[ch]) begin
               // fresh period from a cleared count
               cycCnt <= '0;
               msCnt <= '0;
               pulses <= '0;
               curMs <= integMs[ch];
            end else if (gateStateFlag[ch] && softGateEnable[ch]) begin
               if (periodEnd) begin
                  cycCnt <= '0;
                  msCnt <= '0;
                  pulses <= '0;
                  curMs <= integMs[ch];
               end else begin
                  cycCnt <= msTick ? '0 : cycCnt + 32'h00000001;
                  msCnt <= msTick ? msCnt + 14'h0001 : msCnt;
                  pulses <= pulses + {31'h00000000, risingB};
               end
            end
            // a closing gate just stops; the frozen count is never reported
         end
      end

      // restoring divider, 64 steps: a shorter period would restart it unfinished
      always_ff @(posedge sys_clk or negedge resetn) begin
         if (!resetn) begin
            quo <= '0;
            rem <= '0;
            divisor <= INTEG_RESET_MS;
            steps <= '0;
            divBusy <= 1'b0;
         end else if (clkEn) begin
            if (periodEnd) begin
               // the edge in the closing cycle still belongs to this period
               quo <= 64'(pulses + {31'h00000000, risingB}) * MHZ_SCALE;
               rem <= '0;
               divisor <= curMs;
               steps <= DIV_STEPS;
               divBusy <= 1'b1;
            end else if (divBusy) begin
               if (trial >= {1'b0, divisor}) begin
                  rem <= MS_W'(trial - {1'b0, divisor});
                  quo <= {quo[62:0], 1'b1};
               end else begin
                  rem <= trial[MS_W-1:0];
                  quo <= {quo[62:0], 1'b0};
               end
               steps <= steps - 7'h01;
               divBusy <= (steps != 7'h01);
            end
         end
      end

      // result only moves when a finished period's quotient is ready
      always_ff @(posedge sys_clk or negedge resetn) begin
         if (!resetn) begin
            freq[ch] <= '0;
         end else if (clkEn && divBusy && steps == 7'h01) begin
            // last step folded in here; saturate so the value stays positive
            if (quo[62:30] != '0) begin
               freq[ch] <= {1'b0, FREQ_SAT};
            end else begin
               freq[ch] <= {1'b0, quo[29:0], (trial >= {1'b0, divisor})};
            end
         end
      end
   end

   // job engine: edge-triggered, one cycle of work, done stays high when idle
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         jobReqPrev <= 1'b0;
         jobPend <= 1'b0;
         jobDone <= 1'b1;
         jobErr <= 1'b0;
         jobStat <= STAT_OK;
         jobReadValue <= '0;
         for (int i = 0; i < CHANNELS; i++) begin
            integMs[i] <= INTEG_RESET_MS;
         end
      end else if (clkEn) begin
         jobReqPrev <= jobReq;
         // the logical base address is never decoded
         if (jobReq && !jobReqPrev && !jobPend) begin
            // code, channel and value are taken at the request edge itself
            jobPend <= 1'b1;
            jobDone <= 1'b0;
            jobErr <= 1'b0;
            jobStat <= STAT_OK;
            if (jobChannel >= 2'(CHANNELS)) begin
               jobErr <= 1'b1;
               jobStat <= STAT_BAD_CHAN;
            end else begin
               case (jobCode)
                  JOB_NOP: begin
                  end
                  JOB_WR_INTEG: begin
                     if ($signed(jobWriteValue) < $signed(INTEG_MIN_MS)) begin
                        jobErr <= 1'b1;
                        jobStat <= STAT_TOO_LOW;
                     end else if ($signed(jobWriteValue) > $signed(INTEG_MAX_MS)) begin
                        jobErr <= 1'b1;
                        jobStat <= STAT_TOO_HIGH;
                     end else begin
                        integMs[jobChannel] <= jobWriteValue[MS_W-1:0];
                     end
                  end
                  JOB_RD_INTEG: begin
                     jobReadValue <= {18'h00000, integMs[jobChannel]};
                  end
                  default: begin
                     jobErr <= 1'b1;
                     jobStat <= STAT_BAD_JOB;
                  end
               endcase
            end
         end else if (jobPend) begin
            // one busy cycle, then idle again with the result standing
            jobPend <= 1'b0;
            jobDone <= 1'b1;
         end
      end
   end

   // control register: only interrupt choice and end-of-period enable exist
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         {eomEnable, irqSel} <= CTRL_RESET;
      end else if (clkEn && apbWrite && paddr == REG_CTRL) begin
         irqSel <= pwdata[1:0];
         eomEnable <= pwdata[CTRL_EOM_BIT];
      end
   end

   // process and lost-interrupt flags; a new event beats a clear
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         procIrq <= 1'b0;
         lostFlag <= 1'b0;
         diagIrq <= 1'b0;
      end else if (clkEn) begin
         if (|endEv && eomEnable && irqSel != PFM_IRQ_NONE) begin
            procIrq <= 1'b1;
            if (procIrq && !clrProc) begin
               lostFlag <= 1'b1;
               diagIrq <= (irqSel == PFM_IRQ_DIAG_PROC);
            end else if (clrLost) begin
               lostFlag <= 1'b0;
               diagIrq <= 1'b0;
            end
         end else begin
            if (clrProc) begin
               procIrq <= 1'b0;
            end
            if (clrLost) begin
               lostFlag <= 1'b0;
               diagIrq <= 1'b0;
            end
         end
      end
   end

   // apb answer one cycle into the access phase
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else if (clkEn) begin
         pready <= apbAccess;
         pslverr <= 1'b0;
         prdata <= '0;
         if (apbAccess) begin
            case (paddr)
               REG_CTRL: prdata <= {29'h00000000, eomEnable, irqSel};
               REG_STATUS: prdata <= {27'h0000000, lostFlag, procIrq, gateStateFlag};
               REG_FREQ0: prdata <= freq[0];
               REG_FREQ1: prdata <= freq[1];
               REG_FREQ2: prdata <= freq[2];
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end

endmodule // pfm_freq_meter

//--- pfm_freq_meter_monitor.sv
module pfm_freq_meter_monitor
   import pfm_pkg::*;
#(
   parameter int CYCLES_PER_MS = 4
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic clkEn,
   // gates and result
   input wire logic [CHANNELS-1:0] softGateEnable,
   input wire logic [CHANNELS-1:0] gateStateFlag,
   input wire logic [31:0] measuredFrequency0,
   // job interface
   input wire logic jobReq,
   input wire logic jobDone,
   input wire logic jobErr,
   input wire logic [15:0] jobStat,
   // interrupts
   input wire logic procIrq,
   input wire logic diagIrq,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);
   // job start and its two-step answer
   sequence s_jobStart;
      $rose(jobReq) && jobDone;
   endsequence
   sequence s_jobAnswer;
      !jobDone ##1 jobDone;
   endsequence
   a_job_answer: assert property (s_jobStart |=> s_jobAnswer)
      else $error("job answer out of step");
   a_done_short: assert property (!jobDone |=> jobDone)
      else $error("busy longer than one cycle");
   a_gate_follow: assert property (clkEn |=> gateStateFlag == $past(softGateEnable))
      else $error("gate flag does not follow gate");
   a_err_status: assert property (jobDone |-> jobErr == (jobStat != STAT_OK))
      else $error("error flag and status disagree");
   a_apb_wait: assert property (psel && penable && !pready |=> pready ##1 !pready)
      else $error("register answer not one wait state");
   a_freq_sign: assert property (!measuredFrequency0[31])
      else $error("negative frequency");
   // only a status write with the clear bit may drop the process flag
   a_proc_sticky: assert property (procIrq && !(psel && penable && pready && pwrite &&
      paddr == REG_STATUS && pwdata[STS_PROC_BIT]) |=> procIrq)
      else $error("process interrupt dropped");
   a_diag_cause: assert property ($rose(diagIrq) |-> procIrq)
      else $error("diagnostic without pending interrupt");
endmodule // pfm_freq_meter_monitor

bind pfm_freq_meter pfm_freq_meter_monitor #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_mon (.sys_clk,
   .resetn, .softGateEnable, .gateStateFlag, .measuredFrequency0, .jobReq, .jobDone, .jobErr,
   .jobStat, .procIrq, .diagIrq, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .clkEn);

//--- pfm_pulse_source.sv
module pfm_pulse_source #(
   parameter int P0 = 4,
   parameter int P1 = 8
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // per-channel run and pulse lines
   input wire logic [2:0] run,
   output logic [2:0] pulseB
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;
   // free-running phase; a steady train keeps the edges per window exact
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn)
         cnt <= 0;
      else
         cnt <= cnt + 1;
   end
   // stopped sources sit at their idle low level
   assign pulseB[0] = run[0] && (cnt % P0) < P0 / 2;
   assign pulseB[1] = run[1] && (cnt % P1) < P1 / 2;
   assign pulseB[2] = run[2] && (cnt % P0) < P0 / 2;
endmodule // pfm_pulse_source

//--- pfm_freq_meter_tb.sv
module pfm_freq_meter_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import pfm_pkg::*;
   // 10 and 5 pulses in a 10 ms window, in mHz
   localparam logic [31:0] F0 = 32'h000f4240;
   localparam logic [31:0] F1 = 32'h0007a120;
   logic sys_clk = 1'b0, resetn = 1'b0, clkEn = 1'b1, jobReq = 1'b0, err;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, jobDone, jobErr, procIrq, diagIrq;
   logic [2:0] run = 3'h3, softGateEnable = 3'h0, measInB, gateStateFlag;
   logic [1:0] jobChannel = 2'h0;
   logic [15:0] jobCode = 16'h0, logicalBaseAddress = 16'h0300, jobStat;
   logic [31:0] jobWriteValue = 32'h0, pwdata = 32'h0, prdata, rd, jobReadValue;
   logic [31:0] measuredFrequency0, measuredFrequency1, measuredFrequency2;
   logic [11:0] paddr = 12'h0;
   logic pready, pslverr;
   int miscompares = 0, checks_done = 0, cycles = 0;
   // job table: reads carry the expected time in tVal
   logic [15:0] tCode [10] = '{JOB_WR_INTEG, JOB_WR_INTEG, JOB_RD_INTEG, JOB_WR_INTEG,
      JOB_RD_INTEG, JOB_WR_INTEG, 16'h0005, JOB_NOP, JOB_RD_INTEG, JOB_RD_INTEG};
   logic [31:0] tVal [10] = '{32'h9, 32'h2711, 32'h64, 32'h2710, 32'h2710, 32'ha, 32'h0,
      32'h0, 32'ha, 32'h0};
   logic [15:0] tStat [10] = '{STAT_TOO_LOW, STAT_TOO_HIGH, STAT_OK, STAT_OK, STAT_OK, STAT_OK,
      STAT_BAD_JOB, STAT_OK, STAT_OK, STAT_BAD_CHAN};

   // eight cycles a millisecond keeps a 10 ms period longer than the 64-step divide
   pfm_freq_meter #(.CYCLES_PER_MS(8)) dut (.sys_clk, .resetn, .clkEn, .measInB, .softGateEnable,
      .gateStateFlag, .measuredFrequency0, .measuredFrequency1, .measuredFrequency2, .jobReq,
      .jobChannel, .jobCode, .jobWriteValue, .logicalBaseAddress, .jobDone, .jobErr, .jobStat,
      .jobReadValue, .procIrq, .diagIrq, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr);
   pfm_pulse_source #(.P0(8), .P1(16)) src (.sys_clk, .resetn, .run, .pulseB(measInB));

   // clock and hang guard, far above the roughly six hundred cycles needed
   always #2.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         conclude();
      end
   end

   task automatic conclude();
      $display("checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %0t %s: got %h want %h", $time, msg, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   // one apb transfer, entered just after an edge; waits for pready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask

   // job: done must fall, then rise; base address flips to show it is ignored
   task automatic job(input logic [1:0] ch, input logic [15:0] code, input logic [31:0] v);
      jobChannel <= ch;
      jobCode <= code;
      jobWriteValue <= v;
      jobReq <= 1'b1;
      logicalBaseAddress <= ~logicalBaseAddress;
      @(posedge sys_clk);
      jobReq <= 1'b0;
      do @(posedge sys_clk); while (jobDone !== 1'b0);
      do @(posedge sys_clk); while (jobDone !== 1'b1);
      @(posedge sys_clk);
   endtask

   task automatic t_reset();
      check(jobDone, 1'b1, "idle done");
      check(gateStateFlag, 3'h0, "gate flag");
      check(measuredFrequency0, 32'h0, "freq");
      apb(1'b0, REG_CTRL, 32'h0);
      check(rd, {29'h0, CTRL_RESET}, "ctrl reset");
      job(2'h0, JOB_RD_INTEG, 32'h0);
      check(jobReadValue, {18'h0, INTEG_RESET_MS}, "reset time");
      $display("reset test done");
   endtask

   task automatic t_jobs();
      for (int i = 0; i < 10; i++) begin
         job((i == 9) ? 2'h3 : 2'h0, tCode[i], tVal[i]);
         check(jobStat, tStat[i], "status");
         check(jobErr, tStat[i] != STAT_OK, "error flag");
         if (tCode[i] == JOB_RD_INTEG && tStat[i] == STAT_OK)
            check(jobReadValue, tVal[i], "read value");
      end
      for (int c = 1; c < 3; c++) begin
         job(2'(c), JOB_WR_INTEG, 32'ha);
         check(jobStat, STAT_OK, "write");
      end
      $display("job test done");
   endtask

   // every interrupt selection with end-of-period enabled, then an unmapped read
   task automatic t_ctrl();
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, REG_CTRL, {29'h1, 2'(i)});
         apb(1'b0, REG_CTRL, 32'h0);
         check(rd, {29'h1, 2'(i)}, "ctrl");
      end
      apb(1'b0, 12'h020, 32'h0);
      check({31'h0, err}, 32'h1, "unmapped");
      $display("ctrl test done");
   endtask

   task automatic t_measure();
      softGateEnable <= 3'h7;
      tick(60);
      check(measuredFrequency0, 32'h0, "held");
      check(procIrq, 1'b0, "early irq");
      tick(30);
      check(procIrq, 1'b1, "end irq");
      check(diagIrq, 1'b0, "early lost");
      tick(80);
      check(measuredFrequency0, F0, "ch0");
      check(measuredFrequency1, F1, "ch1");
      check(measuredFrequency2, 32'h0, "ch2 silent");
      check(diagIrq, 1'b1, "lost irq");
      apb(1'b0, REG_STATUS, 32'h0);
      check(rd, 32'h1f, "status");
      $display("measure test done");
   endtask

   // close, clear, then reopen channel 0 with no pulses
   task automatic t_gate();
      softGateEnable <= 3'h0;
      run <= 3'h0;
      tick(150);
      check(measuredFrequency0, F0, "frozen");
      apb(1'b1, REG_STATUS, 32'h18);
      apb(1'b0, REG_STATUS, 32'h0);
      check(rd, 32'h0, "cleared");
      // enable low: the opening gate must not be seen yet
      clkEn <= 1'b0;
      softGateEnable <= 3'h1;
      tick(20);
      check(gateStateFlag, 3'h0, "frozen by enable");
      clkEn <= 1'b1;
      tick(150);
      check(measuredFrequency0, 32'h0, "fresh period");
      check(measuredFrequency1, F1, "ch1 kept");
      $display("gate test done");
   endtask

   initial begin
      tick(4);
      resetn <= 1'b1;
      tick(1);
      t_reset();
      t_jobs();
      t_ctrl();
      t_measure();
      t_gate();
      conclude();
   end
endmodule // pfm_freq_meter_tb
